// ---- core/led_fault_pkg.sv ----
// constants for the led fault status readout block
// assumes a 50 MHz system clock and synchronous active-high reset
package led_fault_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int CHANNELS = 16;
    localparam int MSB_IDX  = CHANNELS - 1;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 20;
    localparam int VALID_DELAY_NS   = 1000;
    localparam int STEP_DELAY_NS    = 30;
    // least times round up to whole cycles
    localparam int VALID_DELAY_CYC  = (VALID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_DELAY_CYC   = (STEP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W          = 8;
    localparam logic [TIMER_W-1:0] TIMER_MAX =
        TIMER_W'(VALID_DELAY_CYC + STEP_DELAY_CYC * MSB_IDX);

    // ------------------------------------------------------------------
    // register bus map
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_ONOFF  = 4'h8;
    localparam logic [3:0] ADDR_LATCH  = 4'hc;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam int CTRL_BLANK_BIT = 0;
    localparam int CTRL_MODE_BIT  = 1;

    // ------------------------------------------------------------------
    // strobe tracking
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FORCE = 3'b010,
        ST_SHIFT = 3'b100
    } strobe_state_e;

endpackage

// ---- core/open_led_detect.sv ----
// per-channel open-led detection with staggered validity delay
// assumes synchronised blank, on/off and low-voltage inputs
`timescale 1ns/1ps
module open_led_detect
    import led_fault_pkg::*;
(
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    // channel conditions
    input  wire logic                blank_in,
    input  wire logic [CHANNELS-1:0] onoff_in,
    input  wire logic [CHANNELS-1:0] low_volt_in,
    // flags
    output logic      [CHANNELS-1:0] flag_out
);

    logic [TIMER_W-1:0] on_timer_reg [CHANNELS];

    function automatic logic [TIMER_W-1:0] valid_at(input int ch);
        return TIMER_W'(VALID_DELAY_CYC + STEP_DELAY_CYC * ch);
    endfunction

    // ------------------------------------------------------------------
    // turn-on timers and flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        for (int ch = 0; ch < CHANNELS; ch++)
        begin
            if (rst_in || blank_in || !onoff_in[ch])
                on_timer_reg[ch] <= '0;
            else if (on_timer_reg[ch] != TIMER_MAX)
                on_timer_reg[ch] <= on_timer_reg[ch] + TIMER_W'(1);
        end
    end

    always_ff @(posedge clk_in)
    begin
        for (int ch = 0; ch < CHANNELS; ch++)
        begin
            if (rst_in)
                flag_out[ch] <= 1'b0;
            else
                flag_out[ch] <= !blank_in && onoff_in[ch] && low_volt_in[ch]
                                && (on_timer_reg[ch] >= valid_at(ch));
        end
    end

endmodule

// ---- core/led_fault_status_readout.sv ----
// Overview of operation
// - overtemperature sets thermal flag, pulls error low
// - cooling clears thermal flag, releases error output
// - open flag needs blank low, on, low voltage
// - any open channel pulls error output low
// - 16-bit status, channel 15 shifted first
// - only faulty and switched-on channel reads one
// - open flag valid only after turn-on delay
// - each channel's validity offset one step later
// - mode low: strobe rise captures all open flags, not the thermal flag
// - latch holds capture until next strobe rise
// - strobe high forces shift register to latch
// - strobe high: serial output shows channel 15
// - strobe fall keeps loaded values, stops forcing
// - each shift clock rise presents next lower channel
// - shifting works with blank high or low
// - forcing beats shifting while strobe high
// - mode low gives 16-bit shift register
// - shift clock rise moves serial input in
// - blank high masks open flags from error output
//
// top of the led fault status readout; pins arrive asynchronously and are
// synchronised to clk_in; on/off data and the blank mask come in over axi4-lite
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module led_fault_status_readout
    import led_fault_pkg::*;
(
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    // serial link pins
    input  wire logic                shift_clk_in,
    input  wire logic                serial_in,
    input  wire logic                latch_strobe_in,
    input  wire logic                blank_in,
    input  wire logic                mode_in,
    output logic                     serial_out,
    // open-drain error pin
    output logic                     error_out_n,
    output logic                     error_oe_n_out,
    // analog sense inputs
    input  wire logic                overtemp_in,
    input  wire logic [CHANNELS-1:0] low_volt_in,
    // axi4-lite write address
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [3:0]          s_axi_awaddr,
    // axi4-lite write data
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    // axi4-lite write response
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic      [1:0]          s_axi_bresp,
    // axi4-lite read address
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [3:0]          s_axi_araddr,
    // axi4-lite read data
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic      [31:0]         s_axi_rdata,
    output logic      [1:0]          s_axi_rresp
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam int SYNC_W = 5 + CHANNELS;
    logic [SYNC_W-1:0]   sync1_reg;
    logic [SYNC_W-1:0]   sync2_reg;
    logic                sclk_s;
    logic                sin_s;
    logic                strobe_s;
    logic                blank_s;
    logic                mode_s;
    logic [CHANNELS-1:0] low_volt_s;
    logic                sclk_prev_reg;
    logic                strobe_prev_reg;
    logic                ot_meta_reg;
    logic                ot_sync_reg;
    logic [CHANNELS-1:0] open_led_flag;
    logic [CHANNELS-1:0] status_latch_reg;
    logic [CHANNELS-1:0] shift_reg;
    logic                thermal_error_flag;
    logic                sclk_rise;
    logic                strobe_rise;
    logic                strobe_fall;
    strobe_state_e       state_reg;
    logic [CHANNELS-1:0] onoff_reg;
    logic                blank_mask_reg;
    logic                aw_hold_reg;
    logic                w_hold_reg;
    logic [3:0]          aw_addr_reg;
    logic [31:0]         w_data_reg;
    logic [3:0]          w_strb_reg;
    logic                do_write;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= {low_volt_in, shift_clk_in, serial_in,
                          latch_strobe_in, blank_in, mode_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign sclk_s   = sync2_reg[4];
    assign sin_s    = sync2_reg[3];
    assign strobe_s = sync2_reg[2];
    assign blank_s  = sync2_reg[1] | blank_mask_reg;
    assign mode_s   = sync2_reg[0];
    assign low_volt_s = sync2_reg[SYNC_W-1 -: CHANNELS];

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ot_meta_reg <= 1'b0;
            ot_sync_reg <= 1'b0;
        end
        else
        begin
            ot_meta_reg <= overtemp_in;
            ot_sync_reg <= ot_meta_reg;
        end
    end

    assign thermal_error_flag = ot_sync_reg;

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sclk_prev_reg   <= 1'b0;
            strobe_prev_reg <= 1'b0;
        end
        else
        begin
            sclk_prev_reg   <= sclk_s;
            strobe_prev_reg <= strobe_s;
        end
    end

    assign sclk_rise   = sclk_s && !sclk_prev_reg;
    assign strobe_rise = strobe_s && !strobe_prev_reg;
    assign strobe_fall = !strobe_s && strobe_prev_reg;

    // ------------------------------------------------------------------
    // open-led detection
    // ------------------------------------------------------------------
    open_led_detect u_detect
    (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .blank_in    (blank_s),
        .onoff_in    (onoff_reg),
        .low_volt_in (low_volt_s),
        .flag_out    (open_led_flag)
    );

    // ------------------------------------------------------------------
    // status latch
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            status_latch_reg <= '0;
        else if (strobe_rise && !mode_s)
            status_latch_reg <= open_led_flag;
    end

    // ------------------------------------------------------------------
    // strobe state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            state_reg <= ST_IDLE;
        else
        begin
            case (state_reg)
                ST_IDLE:  if (strobe_rise && !mode_s) state_reg <= ST_FORCE;
                ST_FORCE: if (strobe_fall) state_reg <= ST_SHIFT;
                ST_SHIFT: if (strobe_rise && !mode_s) state_reg <= ST_FORCE;
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // input shift register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            shift_reg <= '0;
        else if (strobe_rise && !mode_s)
            shift_reg <= open_led_flag;
        else if (state_reg == ST_FORCE && strobe_s)
            shift_reg <= status_latch_reg;
        else if (!strobe_s && sclk_rise && !mode_s)
            shift_reg <= {shift_reg[MSB_IDX-1:0], sin_s};
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            serial_out <= 1'b0;
        else if (strobe_rise && !mode_s)
            serial_out <= open_led_flag[MSB_IDX];
        else if (!strobe_s && sclk_rise && !mode_s)
            serial_out <= shift_reg[MSB_IDX-1];
        else
            serial_out <= shift_reg[MSB_IDX];
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            error_oe_n_out <= 1'b1;
        else
            error_oe_n_out <= !(thermal_error_flag || |open_led_flag);
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            error_out_n <= 1'b1;
        else
            error_out_n <= 1'b0;
    end

    // ------------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------------
    assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            aw_addr_reg   <= '0;
            w_data_reg    <= '0;
            w_strb_reg    <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg == ADDR_CTRL || aw_addr_reg == ADDR_ONOFF)
                                ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            onoff_reg      <= '0;
            blank_mask_reg <= 1'b0;
        end
        else if (do_write)
        begin
            if (aw_addr_reg == ADDR_ONOFF)
            begin
                if (w_strb_reg[0]) onoff_reg[7:0]  <= w_data_reg[7:0];
                if (w_strb_reg[1]) onoff_reg[15:8] <= w_data_reg[15:8];
            end
            if (aw_addr_reg == ADDR_CTRL && w_strb_reg[0])
                blank_mask_reg <= w_data_reg[CTRL_BLANK_BIT];
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL:   s_axi_rdata <= {30'h0, mode_s, blank_mask_reg};
                ADDR_STATUS: s_axi_rdata <= {15'h0, thermal_error_flag, open_led_flag};
                ADDR_ONOFF:  s_axi_rdata <= {16'h0, onoff_reg};
                ADDR_LATCH:  s_axi_rdata <= {16'h0, status_latch_reg};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// ---- test/led_fault_status_readout_assertions.sv ----
// checker for the led fault status readout block
// sees only the top-level ports; bound to every instance of that module
`timescale 1ns/1ps
module led_fault_status_checker (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // link, sense and error pins
    input  wire logic shift_clk_in,
    input  wire logic latch_strobe_in,
    input  wire logic blank_in,
    input  wire logic overtemp_in,
    input  wire logic serial_out,
    input  wire logic error_out_n,
    input  wire logic error_oe_n_out,
    // bus handshakes
    input  wire logic s_axi_awvalid,
    input  wire logic s_axi_awready,
    input  wire logic s_axi_wvalid,
    input  wire logic s_axi_wready,
    input  wire logic s_axi_bvalid,
    input  wire logic s_axi_arvalid,
    input  wire logic s_axi_arready,
    input  wire logic s_axi_rvalid
);
    // ------------------------------------------------------------------
    // cycles since the last rising edge on the shift clock or strobe pin
    // ------------------------------------------------------------------
    logic       sclk_prev_reg;
    logic       strobe_prev_reg;
    logic [3:0] since_rise_reg;

    always_ff @(posedge clk_in)
    begin
        sclk_prev_reg   <= shift_clk_in;
        strobe_prev_reg <= latch_strobe_in;
        if (rst_in)
            since_rise_reg <= 4'hf;
        else if ((shift_clk_in && !sclk_prev_reg) || (latch_strobe_in && !strobe_prev_reg))
            since_rise_reg <= 4'h0;
        else if (since_rise_reg != 4'hf)
            since_rise_reg <= since_rise_reg + 4'h1;
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_hot;
        overtemp_in [*5];
    endsequence
    sequence s_cool;
        (!overtemp_in && blank_in) [*6];
    endsequence
    sequence s_forced;
        latch_strobe_in [*8];
    endsequence
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    property p_therm_low;
        s_hot |-> !error_oe_n_out;
    endproperty
    property p_err_release;
        s_cool |-> error_oe_n_out;
    endproperty
    property p_err_data;
        !$past(rst_in) |-> !error_out_n;
    endproperty
    property p_force_hold;
        s_forced |-> $stable(serial_out);
    endproperty
    property p_out_cause;
        $changed(serial_out) |-> since_rise_reg <= 4'h6;
    endproperty
    property p_write_answer;
        s_write_taken |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
    endproperty
    property p_busy_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_read_refuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty

    a_therm_low: assert property (p_therm_low)
        else $error("error pin not pulled on overtemperature");
    a_err_release: assert property (p_err_release)
        else $error("error pin not released");
    a_err_data: assert property (p_err_data)
        else $error("open-drain data not low");
    a_force_hold: assert property (p_force_hold)
        else $error("serial output moved while strobe high");
    a_out_cause: assert property (p_out_cause)
        else $error("serial output moved without a link edge");
    a_write_answer: assert property (p_write_answer)
        else $error("write response late");
    a_read_answer: assert property (p_read_answer)
        else $error("read data late");
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("write accepted while response pending");
    a_read_refuse: assert property (p_read_refuse)
        else $error("read accepted while data pending");
endmodule

bind led_fault_status_readout led_fault_status_checker u_chk (.*);

// ---- test/link_host_model.sv ----
// host-side model driving the serial link pins, blank and mode
// assumes it is the only driver of those pins; link period 160 ns
`timescale 1ns/1ps
module link_host_model (
    // status from the device
    input  wire logic        serial_out_in,
    // link pins
    output logic             sclk_out,
    output logic             sdata_out,
    output logic             strobe_out,
    output logic             blank_out,
    output logic             mode_out,
    // captured readout
    output logic [31:0]      word_out,
    output logic             done_out
);
    initial
    begin
        sclk_out   = 1'b0;
        sdata_out  = 1'b0;
        strobe_out = 1'b0;
        blank_out  = 1'b1;
        mode_out   = 1'b0;
        word_out   = '0;
        done_out   = 1'b0;
    end

    task automatic set_ctl(input logic b, input logic m);
        blank_out <= b;
        mode_out  <= m;
    endtask

    // strobe raised with blank held low by caller; one shift pulse inside
    task automatic pulse_strobe();
        #7 strobe_out = 1'b1;
        #40 sclk_out = 1'b1;
        sdata_out = ~sdata_out;
        #80 sclk_out = 1'b0;
        #40 strobe_out = 1'b0;
    endtask

    // own status, then the chained word fed in at the serial input
    task automatic readout(input logic [15:0] chain);
        int i;
        #13 sdata_out = chain[15];
        for (i = 0; i < 32; i++)
        begin
            #80 word_out[31 - i] = serial_out_in;
            sclk_out = 1'b1;
            #80 sclk_out = 1'b0;
            sdata_out = (i < 15) ? chain[14 - i] : ~sdata_out;
        end
        done_out = 1'b1;
        #20 done_out = 1'b0;
    endtask
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the led fault status readout block
// assumes the host model drives the link pins, blank and mode
`timescale 1ns/1ps
module testbench
    import led_fault_pkg::*;
;
    logic        clk_in, rst_in, overtemp_in, serial_out, error_out_n, error_oe_n_out;
    logic        shift_clk_in, serial_in, latch_strobe_in, blank_in, mode_in, done;
    logic [15:0] low_volt_in, on, lv, cap, chain;
    logic [31:0] word, seed, s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [63:0] exp_q[$];
    int          error_cnt, checked, cycles, k;

    led_fault_status_readout DUT (.*);
    link_host_model host (
        .serial_out_in    (serial_out),
        .sclk_out   (shift_clk_in),
        .sdata_out  (serial_in),
        .strobe_out (latch_strobe_in),
        .blank_out  (blank_in),
        .mode_out   (mode_in),
        .word_out   (word),
        .done_out   (done)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] rnd();
        repeat (16)
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction

    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic take(input string nm, input logic [31:0] s);
        logic [63:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
        cmp(nm, e[31:0], s & e[63:32]);
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r);
        exp_q.push_back({32'h3, 30'h0, r});
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] d);
        exp_q.push_back({m, d});
        exp_q.push_back({32'h3, 30'h0, (a[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge clk_in);
    endtask

    // ------------------------------------------------------------------
    // clock, watchdog and result monitor
    // ------------------------------------------------------------------
    always #10 clk_in = ~clk_in;

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    always @(posedge clk_in)
    begin
        if (s_axi_bvalid && s_axi_bready)
            take("bresp", {30'h0, s_axi_bresp});
        if (s_axi_rvalid && s_axi_rready)
            take("rdata", s_axi_rdata);
        if (s_axi_rvalid && s_axi_rready)
            take("rresp", {30'h0, s_axi_rresp});
    end

    always @(posedge done)
        take("readout", word);

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        clk_in = 1'b0;
        rst_in = 1'b1;
        seed = 32'h2628;
        overtemp_in = 1'b0;
        low_volt_in = '0;
        cap = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        overtemp_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        axi_rd(ADDR_STATUS, 32'h10000, 32'h10000);
        cmp("error_oe_n", 32'h0, {31'h0, error_oe_n_out});
        overtemp_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        cmp("error_oe_n", 32'h1, {31'h0, error_oe_n_out});
        axi_rd(ADDR_STATUS, 32'h1ffff, 32'h0);
        axi_wr(ADDR_STATUS, 16'hffff, RESP_SLVERR);
        axi_wr(ADDR_LATCH, 16'hffff, RESP_SLVERR);
        axi_rd(4'h6, 32'hffffffff, 32'h0);
        axi_wr(ADDR_CTRL, 16'h1, RESP_OKAY);
        axi_rd(ADDR_CTRL, 32'h3, 32'h1);
        axi_wr(ADDR_CTRL, 16'h0, RESP_OKAY);
        for (k = 0; k < 4; k++)
        begin
            on = rnd();
            lv = rnd();
            chain = rnd();
            host.set_ctl(1'b1, 1'b0);
            axi_wr(ADDR_ONOFF, on, RESP_OKAY);
            axi_rd(ADDR_ONOFF, 32'hffff, {16'h0, on});
            low_volt_in <= lv;
            host.set_ctl(1'b0, k == 2);
            repeat (40) @(posedge clk_in);
            axi_rd(ADDR_STATUS, 32'hffff, 32'h0);
            repeat (20) @(posedge clk_in);
            axi_rd(ADDR_STATUS, 32'hfc0f, {28'h0, on[3:0] & lv[3:0]});
            repeat (60) @(posedge clk_in);
            axi_rd(ADDR_STATUS, 32'h1ffff, {16'h0, on & lv});
            cmp("error_oe_n", {31'h0, (on & lv) == 16'h0}, {31'h0, error_oe_n_out});
            if (k == 2)
                axi_rd(ADDR_CTRL, 32'h3, 32'h2);
            host.pulse_strobe();
            @(posedge clk_in);
            if (k != 2)
                cap = on & lv;
            low_volt_in <= rnd();
            repeat (4) @(posedge clk_in);
            axi_rd(ADDR_LATCH, 32'hffff, {16'h0, cap});
            if (k != 2)
            begin
                host.set_ctl(k[0], 1'b0);
                exp_q.push_back({32'hffffffff, cap, chain});
                host.readout(chain);
                @(posedge clk_in);
            end
        end
        end_of_test();
    end
endmodule
